// ### logic/stl_regs.svh
// Purpose: constants of the self-test and LED display block
// Assumes: 100 MHz clock
// Notes: timing counts are derived from the times below
`ifndef STL_REGS_SVH
`define STL_REGS_SVH
`define STL_CLK_MHZ 100
`define STL_SWEEP_MS 2000
`define STL_HOLD_MS 2000
`define STL_WIN_US 2000
`define STL_LEDS 8
`define STL_STEP_CYC ((`STL_SWEEP_MS * 1000 * `STL_CLK_MHZ) / `STL_LEDS)
`define STL_HOLD_CYC (`STL_HOLD_MS * 1000 * `STL_CLK_MHZ)
`define STL_WIN_CYC (`STL_WIN_US * `STL_CLK_MHZ)
`define STL_DIAG_CMD 16'hAA00
`define STL_LED_RST 8'h00
`define STL_WALK_FIRST 8'h80
`define STL_CODE_FIRST 8'h02
`define STL_CODE_CORE_LAST 8'h0E
`define STL_CODE_UNUSED_LO 8'h0F
`define STL_CODE_UNUSED_HI 8'h12
`define STL_CODE_RAM_ADDR 8'h13
`define STL_CODE_RAM_DATA 8'h14
`define STL_CORE_STEPS 5'd13
`define STL_LAST_STEP 5'd14
`define STL_RATE_MAX 8'hFF
`endif

// ### logic/stl_pkg.sv
// Purpose: types of the self-test and LED display block
// Assumes: nothing
// Notes: one packed struct holds all block state
package stl_pkg;
  typedef enum logic [2:0] {
    ST_START = 3'b000,
    ST_TEST = 3'b001,
    ST_FAIL = 3'b010,
    ST_SWEEP = 3'b011,
    ST_SHOW_RX = 3'b100,
    ST_SHOW_TX = 3'b101
  } stl_state_e;
  typedef struct packed {
    stl_state_e st;
    logic [4:0] step;
    logic [2:0] bit_idx;
    logic [31:0] tmr;
    logic [31:0] win;
    logic [7:0] led;
    logic [7:0] code;
    logic go;
    logic busy;
    logic pass;
    logic btn;
    logic [7:0] rx_cnt;
    logic [7:0] tx_cnt;
    logic [7:0] rx_pk;
    logic [7:0] tx_pk;
  } stl_state_s;
endpackage

// ### logic/stl_selftest.sv
// Purpose: self-test sequencer with eight-LED result and rate display
// Assumes: inputs synchronous to clk; test engine answers each step
// Notes: rate window of 2 ms makes the window count the display unit
// What this block does
// RULE1: a test run starts after reset, on a button press and on bus init.
// RULE2: writing AA00 hex to the diagnostic register also starts a run.
// RULE3: results appear on eight LED outputs, bit 7 most significant.
// RULE4: after a pass one LED walks from 7 to 0, the sweep taking two seconds.
// RULE5: then the peak receive rate of all lines shows for two seconds.
// RULE6: then the peak transmit rate of all lines shows for two seconds.
// RULE7: then the sweep, receive and transmit displays repeat forever.
// RULE8: a shown rate is characters per second times 2 over 1000.
// RULE9: each peak covers only the time since it was last shown.
// RULE10: a failure shows the code of the failed test, never code 00.
// RULE11: core tests use codes 02 to 09, one per core check, in a fixed order.
// RULE12: codes 0A to 0E follow and codes 0F to 12 are skipped.
// RULE13: shared RAM addressing fails with 13, data with 14, and holds.
`timescale 1ns/1ps
`include "stl_regs.svh"
module stl_selftest #(
  parameter int STEP_CYC = `STL_STEP_CYC,
  parameter int HOLD_CYC = `STL_HOLD_CYC,
  parameter int WIN_CYC = `STL_WIN_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic btn_in,
  input wire logic bus_init,
  input wire logic diag_wr,
  input wire logic [15:0] diag_wdata,
  input wire logic step_done,
  input wire logic step_ok,
  input wire logic rx_char,
  input wire logic tx_char,
  output logic [7:0] led,
  output logic test_go,
  output logic [7:0] test_code,
  output logic test_busy,
  output logic test_pass
);
  localparam logic [31:0] STEP_LAST = 32'(STEP_CYC - 1);
  localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYC - 1);
  localparam logic [31:0] WIN_LAST = 32'(WIN_CYC - 1);

  stl_pkg::stl_state_s s_q;
  stl_pkg::stl_state_s s_d;
  logic trig;
  logic win_end;
  logic [7:0] rx_pk_n;
  logic [7:0] tx_pk_n;
  logic clr_rx;
  logic clr_tx;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] step_code(input logic [4:0] idx);
    logic [7:0] c;
    if (idx < `STL_CORE_STEPS) begin
      c = `STL_CODE_FIRST + {3'h0, idx}; // [RULE11] [RULE12]
    end else if (idx == `STL_CORE_STEPS) begin
      c = `STL_CODE_RAM_ADDR; // [RULE13]
    end else begin
      c = `STL_CODE_RAM_DATA; // [RULE13]
    end
    return c;
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic inc);
    logic [7:0] r;
    r = (inc && v != `STL_RATE_MAX) ? v + 8'h01 : v;
    return r;
  endfunction

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = (a > b) ? a : b;
    return r;
  endfunction

  // ------------------------------------------------------------
  // triggers
  // ------------------------------------------------------------
  assign trig = (btn_in & ~s_q.btn) | bus_init // [RULE1]
              | (diag_wr & (diag_wdata == `STL_DIAG_CMD)); // [RULE2]

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    clr_rx = 1'b0;
    clr_tx = 1'b0;
    s_d.go = 1'b0;
    s_d.btn = btn_in;
    // window of 2 ms: count equals rate in units of 500 per second
    win_end = (s_q.win == WIN_LAST);
    s_d.win = win_end ? 32'h0 : s_q.win + 32'h1;
    rx_pk_n = win_end ? max8(s_q.rx_pk, s_q.rx_cnt) : s_q.rx_pk; // [RULE8]
    tx_pk_n = win_end ? max8(s_q.tx_pk, s_q.tx_cnt) : s_q.tx_pk; // [RULE8]
    s_d.rx_cnt = win_end ? {7'h0, rx_char} : sat_inc(s_q.rx_cnt, rx_char);
    s_d.tx_cnt = win_end ? {7'h0, tx_char} : sat_inc(s_q.tx_cnt, tx_char);
    case (s_q.st)
      stl_pkg::ST_START: begin
        s_d.step = 5'd0;
        s_d.code = step_code(5'd0);
        s_d.led = step_code(5'd0);
        s_d.go = 1'b1;
        s_d.busy = 1'b1;
        s_d.pass = 1'b0;
        s_d.st = stl_pkg::ST_TEST;
      end
      stl_pkg::ST_TEST: begin
        if (step_done && !s_q.go) begin
          if (!step_ok) begin
            s_d.st = stl_pkg::ST_FAIL; // [RULE10]
            s_d.led = s_q.code; // [RULE3] [RULE10]
            s_d.busy = 1'b0;
          end else if (s_q.step == `STL_LAST_STEP) begin
            s_d.st = stl_pkg::ST_SWEEP;
            s_d.busy = 1'b0;
            s_d.pass = 1'b1;
            s_d.tmr = 32'h0;
            s_d.bit_idx = 3'd0;
            s_d.led = `STL_WALK_FIRST; // [RULE4]
          end else begin
            s_d.step = s_q.step + 5'd1;
            s_d.code = step_code(s_q.step + 5'd1);
            s_d.led = step_code(s_q.step + 5'd1);
            s_d.go = 1'b1;
          end
        end
      end
      stl_pkg::ST_FAIL: begin
        s_d.st = stl_pkg::ST_FAIL; // [RULE13]
      end
      stl_pkg::ST_SWEEP: begin
        if (s_q.tmr == STEP_LAST) begin
          s_d.tmr = 32'h0;
          if (s_q.bit_idx == 3'd7) begin
            s_d.st = stl_pkg::ST_SHOW_RX;
            s_d.led = rx_pk_n; // [RULE5]
            clr_rx = 1'b1;
          end else begin
            s_d.bit_idx = s_q.bit_idx + 3'd1;
            s_d.led = s_q.led >> 1; // [RULE4]
          end
        end else begin
          s_d.tmr = s_q.tmr + 32'h1;
        end
      end
      stl_pkg::ST_SHOW_RX: begin
        if (s_q.tmr == HOLD_LAST) begin
          s_d.tmr = 32'h0;
          s_d.st = stl_pkg::ST_SHOW_TX;
          s_d.led = tx_pk_n; // [RULE6]
          clr_tx = 1'b1;
        end else begin
          s_d.tmr = s_q.tmr + 32'h1;
        end
      end
      stl_pkg::ST_SHOW_TX: begin
        if (s_q.tmr == HOLD_LAST) begin
          s_d.tmr = 32'h0;
          s_d.st = stl_pkg::ST_SWEEP; // [RULE7]
          s_d.bit_idx = 3'd0;
          s_d.led = `STL_WALK_FIRST;
        end else begin
          s_d.tmr = s_q.tmr + 32'h1;
        end
      end
      default: begin
        s_d.st = stl_pkg::ST_START;
      end
    endcase
    s_d.rx_pk = clr_rx ? 8'h00 : rx_pk_n; // [RULE9]
    s_d.tx_pk = clr_tx ? 8'h00 : tx_pk_n; // [RULE9]
    if (trig) begin
      s_d.st = stl_pkg::ST_START; // [RULE1] [RULE2]
      s_d.go = 1'b0;
      s_d.tmr = 32'h0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{st: stl_pkg::ST_START, step: 5'd0, bit_idx: 3'd0,
               tmr: 32'h0, win: 32'h0, led: `STL_LED_RST, code: 8'h00,
               go: 1'b0, busy: 1'b1, pass: 1'b0, btn: 1'b0,
               rx_cnt: 8'h00, tx_cnt: 8'h00, rx_pk: 8'h00, tx_pk: 8'h00}; // [RULE1]
    end else begin
      s_q <= s_d;
    end
  end

  assign led = s_q.led;
  assign test_go = s_q.go;
  assign test_code = s_q.code;
  assign test_busy = s_q.busy;
  assign test_pass = s_q.pass;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sweep_end_s;
    s_q.st == stl_pkg::ST_SWEEP && s_q.tmr == STEP_LAST && s_q.bit_idx == 3'd7;
  endsequence
  sequence start_go_s;
    s_q.st == stl_pkg::ST_START ##1 s_q.go && s_q.st == stl_pkg::ST_TEST;
  endsequence
  // a passing step with more steps to run
  sequence next_step_s;
    s_q.st == stl_pkg::ST_TEST && step_done && step_ok && !s_q.go && !trig
    && s_q.step != `STL_LAST_STEP;
  endsequence
  sequence last_step_s;
    s_q.st == stl_pkg::ST_TEST && step_done && step_ok && !s_q.go && !trig
    && s_q.step == `STL_LAST_STEP;
  endsequence

  trig_start_a: assert property ((btn_in && !s_q.btn) || bus_init |=> start_go_s) // [RULE1]
    else $error("trigger did not start a test run");
  diag_cmd_a: assert property (diag_wr && diag_wdata == `STL_DIAG_CMD |=> start_go_s) // [RULE2]
    else $error("diagnostic command did not start a test run");
  diag_other_a: assert property (diag_wr && diag_wdata != `STL_DIAG_CMD && !bus_init // [RULE2]
    && !(btn_in && !s_q.btn) |=> s_q.st != stl_pkg::ST_START)
    else $error("test run started without a trigger");
  walk_one_a: assert property (s_q.st == stl_pkg::ST_SWEEP // [RULE4]
    |-> led == (`STL_WALK_FIRST >> s_q.bit_idx) && $onehot(led))
    else $error("walking pattern wrong");
  sweep_step_a: assert property (s_q.st == stl_pkg::ST_SWEEP && s_q.tmr == STEP_LAST // [RULE4]
    && s_q.bit_idx != 3'd7 && !trig |=> led == $past(led) >> 1)
    else $error("walking one did not advance");
  rx_show_a: assert property (sweep_end_s and !trig // [RULE5]
    |=> s_q.st == stl_pkg::ST_SHOW_RX && led == $past(rx_pk_n) && s_q.rx_pk == 8'h00)
    else $error("receive peak not shown or not restarted");
  tx_show_a: assert property (s_q.st == stl_pkg::ST_SHOW_RX && s_q.tmr == HOLD_LAST // [RULE6]
    && !trig |=> s_q.st == stl_pkg::ST_SHOW_TX && led == $past(tx_pk_n) && s_q.tx_pk == 8'h00)
    else $error("transmit peak not shown or not restarted");
  loop_back_a: assert property (s_q.st == stl_pkg::ST_SHOW_TX && s_q.tmr == HOLD_LAST // [RULE7]
    && !trig |=> s_q.st == stl_pkg::ST_SWEEP && led == `STL_WALK_FIRST)
    else $error("display cycle did not repeat");
  fail_hold_a: assert property (s_q.st == stl_pkg::ST_FAIL && !trig // [RULE13]
    |=> s_q.st == stl_pkg::ST_FAIL && $stable(led) && led != 8'h00)
    else $error("failure code not held");
  code_map_a: assert property (test_go |-> test_code >= `STL_CODE_FIRST // [RULE12]
    && test_code <= `STL_CODE_RAM_DATA
    && !(test_code >= `STL_CODE_UNUSED_LO && test_code <= `STL_CODE_UNUSED_HI))
    else $error("illegal test code issued");
  fail_code_a: assert property (s_q.st == stl_pkg::ST_TEST && step_done && !step_ok // [RULE10]
    && !s_q.go && !trig |=> s_q.st == stl_pkg::ST_FAIL && led == $past(test_code))
    else $error("failed step code not shown");
  trig_abort_a: assert property (trig |=> s_q.st == stl_pkg::ST_START && !test_go) // [RULE1]
    else $error("trigger did not restart the run");
  start_code_a: assert property (s_q.st == stl_pkg::ST_START && !trig // [RULE11]
    |=> test_go && test_code == `STL_CODE_FIRST && led == `STL_CODE_FIRST)
    else $error("run did not start with the first code");
  go_pulse_a: assert property (test_go |=> !test_go) // [RULE11]
    else $error("step start held longer than one cycle");
  busy_run_a: assert property (s_q.st == stl_pkg::ST_TEST |-> test_busy) // [RULE1]
    else $error("busy low during a test run");
  code_nonzero_a: assert property ((s_q.st == stl_pkg::ST_TEST // [RULE10]
    || s_q.st == stl_pkg::ST_FAIL) |-> led != 8'h00)
    else $error("illegal code zero shown");
  step_next_a: assert property (next_step_s |=> test_go && led == test_code // [RULE11] [RULE12]
    && (test_code == $past(test_code) + 8'h01
    || ($past(test_code) == `STL_CODE_CORE_LAST && test_code == `STL_CODE_RAM_ADDR)))
    else $error("next step code out of order");
  pass_entry_a: assert property (last_step_s |=> s_q.st == stl_pkg::ST_SWEEP // [RULE4]
    && test_pass && !test_busy && led == `STL_WALK_FIRST)
    else $error("passing run did not start the sweep");
  fail_idle_a: assert property (s_q.st == stl_pkg::ST_FAIL // [RULE10]
    |-> !test_busy && !test_pass && !test_go)
    else $error("failed run still marked busy or passed");
  fail_range_a: assert property (s_q.st == stl_pkg::ST_FAIL // [RULE12]
    |-> led >= `STL_CODE_FIRST && led <= `STL_CODE_RAM_DATA
    && !(led >= `STL_CODE_UNUSED_LO && led <= `STL_CODE_UNUSED_HI))
    else $error("failure code outside the code table");

  // ------------------------------------------------------------
  // display timing
  // ------------------------------------------------------------
  sweep_hold_a: assert property (s_q.st == stl_pkg::ST_SWEEP && s_q.tmr != STEP_LAST // [RULE4]
    && !trig |=> s_q.st == stl_pkg::ST_SWEEP && $stable(led))
    else $error("walking one moved early");
  rx_hold_a: assert property (s_q.st == stl_pkg::ST_SHOW_RX && s_q.tmr != HOLD_LAST // [RULE5]
    && !trig |=> s_q.st == stl_pkg::ST_SHOW_RX && $stable(led))
    else $error("receive peak not held");
  tx_hold_a: assert property (s_q.st == stl_pkg::ST_SHOW_TX && s_q.tmr != HOLD_LAST // [RULE6]
    && !trig |=> s_q.st == stl_pkg::ST_SHOW_TX && $stable(led))
    else $error("transmit peak not held");

  // peaks only fall when they are shown
  rx_keep_a: assert property (!clr_rx |=> s_q.rx_pk >= $past(s_q.rx_pk)) // [RULE9]
    else $error("receive peak lost before display");
  tx_keep_a: assert property (!clr_tx |=> s_q.tx_pk >= $past(s_q.tx_pk)) // [RULE9]
    else $error("transmit peak lost before display");
endmodule

// ### verification/stl_engine_model.sv
// Purpose: test engine model answering each step of a run
// Assumes: test_go is a one-cycle pulse with test_code valid
// Notes: answers after 2 or 3 cycles; fails only the step named by fail_code
`timescale 1ns/1ps
module stl_engine_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic test_go,
  input wire logic [7:0] test_code,
  input wire logic [7:0] fail_code,
  output logic step_done,
  output logic step_ok
);
  logic [1:0] cnt_q;
  logic [7:0] code_q;
  // ----------------------------------------
  // step answer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      code_q <= 8'h00;
      step_done <= 1'b0;
      step_ok <= 1'b0;
    end else begin
      step_done <= 1'b0;
      // result line toggles outside answers, never a stale valid value
      step_ok <= ~step_ok;
      if (test_go) begin
        cnt_q <= {1'b1, test_code[0]};
        code_q <= test_code;
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          step_done <= 1'b1;
          step_ok <= (code_q != fail_code);
        end
      end
    end
  end
endmodule

// ### verification/tb_stl_selftest.sv
// Purpose: self-checking bench of the self-test and LED display block
// Assumes: short counts STEP_CYC 4, HOLD_CYC 6, WIN_CYC 5
// Notes: inputs driven and outputs sampled 1 ns after the rising edge
`timescale 1ns/1ps
module tb_stl_selftest;
  localparam int STEP = 4;
  localparam int HOLD = 6;
  localparam int WIN = 5;
  localparam logic [7:0] CODES [15] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h13, 8'h14};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic btn_in = 1'b0;
  logic bus_init = 1'b0;
  logic diag_wr = 1'b0;
  logic [15:0] diag_wdata = 16'h0000;
  logic rx_char = 1'b1;
  logic tx_char = 1'b1;
  logic [7:0] fail_code = 8'h00;
  logic step_done, step_ok, test_go, test_busy, test_pass;
  logic [7:0] led, test_code;
  int n_fail = 0;
  int checked = 0;
  always #5 clk = ~clk;
  stl_selftest #(.STEP_CYC(STEP), .HOLD_CYC(HOLD), .WIN_CYC(WIN)) dut (.clk(clk),
    .rst_n(rst_n), .btn_in(btn_in), .bus_init(bus_init), .diag_wr(diag_wr),
    .diag_wdata(diag_wdata), .step_done(step_done), .step_ok(step_ok), .rx_char(rx_char),
    .tx_char(tx_char), .led(led), .test_go(test_go), .test_code(test_code),
    .test_busy(test_busy), .test_pass(test_pass));
  stl_engine_model partner (.clk(clk), .rst_n(rst_n), .test_go(test_go),
    .test_code(test_code), .fail_code(fail_code), .step_done(step_done), .step_ok(step_ok));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task summarize;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task wait_for(input int which);
    for (int i = 0; i < 400; i++) begin
      tick;
      if (which == 0 && test_go === 1'b1) return;
      if (which == 1 && test_busy === 1'b0) return;
    end
    $display("wrong value wait %0d expected done seen timeout", which);
    n_fail++;
    summarize;
  endtask
  task run_codes(input logic [7:0] last);
    chk("go", 8'h01, {7'h00, test_go});
    chk("test_code", CODES[0], test_code);
    for (int i = 1; i < 15 && CODES[i - 1] !== last; i++) begin
      wait_for(0);
      chk("test_code", CODES[i], test_code);
      chk("led", CODES[i], led);
    end
    wait_for(1);
  endtask
  task trigger(input int kind);
    diag_wr = (kind == 0 || kind == 3);
    diag_wdata = (kind == 0) ? 16'hAA00 : 16'h1234;
    btn_in = (kind == 1);
    bus_init = (kind == 2);
    tick;
    diag_wr = 1'b0;
    btn_in = 1'b0;
    bus_init = 1'b0;
    tick;
  endtask
  task show_cycle(input logic [7:0] rx_exp, input logic [7:0] tx_exp, input logic tx_on);
    tx_char = tx_on;
    for (int b = 0; b < 8; b++) begin
      repeat (STEP) begin
        chk("sweep", 8'h80 >> b, led);
        tick;
      end
    end
    tx_char = 1'b0;
    repeat (HOLD) begin
      chk("rx peak", rx_exp, led);
      tick;
    end
    repeat (HOLD) begin
      chk("tx peak", tx_exp, led);
      tick;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_power_up;
    repeat (8) tick;
    chk("reset led", 8'h00, led);
    chk("reset busy", 8'h01, {7'h00, test_busy});
    rst_n = 1'b1;
    tick;
    run_codes(8'h14);
    chk("pass", 8'h01, {7'h00, test_pass});
    $display("test power_up done");
  endtask
  task t_display;
    rx_char = 1'b0;
    show_cycle(8'(WIN), 8'(WIN), 1'b0);
    show_cycle(8'h00, 8'(WIN), 1'b1);
    chk("sweep again", 8'h80, led);
    $display("test display done");
  endtask
  task t_fail_restart;
    fail_code = 8'h13;
    trigger(0);
    run_codes(8'h13);
    repeat (10) tick;
    chk("fail led", 8'h13, led);
    trigger(3);
    chk("refused write", 8'h13, led);
    chk("refused busy", 8'h00, {7'h00, test_busy});
    fail_code = 8'h05;
    trigger(1);
    run_codes(8'h05);
    chk("fail led", 8'h05, led);
    chk("fail pass", 8'h00, {7'h00, test_pass});
    fail_code = 8'h00;
    trigger(2);
    run_codes(8'h14);
    chk("pass led", 8'h80, led);
    $display("test fail_restart done");
  endtask
  initial begin
    t_power_up;
    t_display;
    t_fail_restart;
    summarize;
  end
endmodule
